// [acsr_pkg.sv]
/*
 * Shared constants and carrier types for the transceiver configuration and status register bank.
 * Assumes the op-code byte arrives already shifted in, with its two low bits ignored.
 */
`default_nettype none
package acsr_pkg;
	// op-codes with the two don't-care bits cleared
	localparam logic [7:0] OP_MASK = 8'hFC;
	localparam logic [7:0] OP_MR = 8'h04;
	localparam logic [7:0] OP_WR_TXC = 8'h08;
	localparam logic [7:0] OP_WR_TXF = 8'h0C;
	localparam logic [7:0] OP_WR_RXC = 8'h10;
	localparam logic [7:0] OP_WR_LAB = 8'h14;
	localparam logic [7:0] OP_WR_PLM = 8'h18;
	localparam logic [7:0] OP_WR_PIN = 8'h34;
	localparam logic [7:0] OP_WR_DIV = 8'h38;
	localparam logic [7:0] OP_TX_GO = 8'h40;
	localparam logic [7:0] OP_SR = 8'h44;
	localparam logic [7:0] OP_SET_LAB = 8'h48;
	localparam logic [7:0] OP_RD_TXS = 8'h80;
	localparam logic [7:0] OP_RD_TXC = 8'h84;
	localparam logic [7:0] OP_RD_RXS = 8'h90;
	localparam logic [7:0] OP_RD_RXC = 8'h94;
	localparam logic [7:0] OP_RD_LAB = 8'h98;
	localparam logic [7:0] OP_RD_PLM = 8'h9C;
	localparam logic [7:0] OP_RD_FIFO = 8'hA0;
	localparam logic [7:0] OP_RD_MB = 8'hA4;
	localparam logic [7:0] OP_RD_PIN = 8'hD0;
	localparam logic [7:0] OP_RD_DIV = 8'hD4;
	// receiver two op-codes sit at these distances from receiver one; mailbox op-codes sit MB_STEP apart
	localparam logic [7:0] RX2_WR_STEP = 8'h14;
	localparam logic [7:0] RX2_RD_STEP = 8'h20;
	localparam logic [7:0] SET_LAB_STEP = 8'h04;
	localparam logic [7:0] MB_STEP = 8'h04;
	// receiver control fields
	localparam int RC_FLIP = 7;
	localparam int RC_SD9 = 6;
	localparam int RC_SRC_DEST_COMPARE_HI = 5;
	localparam int RC_SRC_DEST_FILTER_ENABLE = 4;
	localparam int RC_PAR = 3;
	localparam int RC_LABF = 2;
	localparam int RC_PRIORITY_CAPTURE_ENABLE = 1;
	localparam int CTL_RATE = 0;
	// transmit control fields
	localparam int TC_FLOAT = 7;
	localparam int TC_FLIP = 6;
	localparam int TC_AUTO = 5;
	localparam int TC_LOOP = 4;
	localparam int TC_SENSE = 3;
	localparam int TC_PINS = 2;
	// divider keeps only bits 4..1
	localparam logic [7:0] DIV_MASK = 8'h1E;
	localparam logic [4:0] DIV_UNITY = 5'h01;
	// pin assignment: receiver n flag field at 4n, event field at 4n+2
	localparam int PIN_FLAG_LSB = 0;
	localparam int PIN_INT_LSB = 2;
	localparam int PIN_RX_STEP = 4;
	localparam logic [1:0] FLAG_EMPTY = 2'b00;
	localparam logic [1:0] FLAG_FULL = 2'b01;
	localparam logic [1:0] FLAG_HALF = 2'b10;
	localparam logic [1:0] INT_ANY = 2'b00;
	// queue levels in words and transfer lengths in bytes
	localparam logic [5:0] Q_FULL = 6'h20;
	localparam logic [5:0] Q_HALF = 6'h10;
	localparam logic [5:0] LEN_WORD = 6'h04;
	localparam logic [5:0] LEN_LAB = 6'h20;
	localparam logic [5:0] LEN_PLM = 6'h03;
	localparam int N_MB = 3;

	typedef struct packed {
		logic valid;
		logic [31:0] word;
	} acsr_word_t;

	typedef struct packed {
		logic [1:0][7:0] rx_ctl;
		logic [7:0] tx_ctl;
		logic [7:0] div;
		logic [7:0] pin;
		logic [1:0][255:0] lab;
		logic [1:0][2:0][7:0] match;
		logic [1:0][2:0][23:0] mbox;
		logic [1:0][2:0] capt;
		logic [7:0] op;
		logic [5:0] cnt;
		logic [31:0] word;
		logic [7:0] rd_byte;
		logic tx_go;
		logic [31:0] tx_word;
		acsr_word_t [1:0] rx_push;
		acsr_word_t tx_push;
		logic [1:0] ev;
		logic clr;
	} acsr_state_t;
endpackage
`default_nettype wire

// [acsr_regs.sv]
/*
 * Configuration and status register bank of a two-receiver, one-transmitter serial avionics transceiver.
 * Assumes an SPI shifter on clk_i that presents the op-code, then each written byte, and asks for each read byte after the first;
 * validated receive words, queue fill counts and a show-ahead queue head all come from logic on clk_i.
 * Word bit 0 is the first bit on the line (label MSB); word bit 31 is the last (parity).
 */
`default_nettype none
module acsr_regs
	import acsr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic op_start_i,
	input wire logic [7:0] op_code_i,
	input wire logic wr_byte_valid_i,
	input wire logic [7:0] wr_byte_i,
	input wire logic rd_byte_req_i,
	output logic [7:0] rd_byte_o,
	input wire acsr_word_t [1:0] rx_word_i,
	input wire logic [1:0][5:0] rx_count_i,
	input wire logic [1:0][31:0] rx_head_i,
	output logic [1:0] rx_pop_o,
	output acsr_word_t [1:0] rx_push_o,
	input wire logic [5:0] tx_count_i,
	input wire logic tx_load_i,
	input wire logic [31:0] tx_head_i,
	output logic [31:0] tx_word_o,
	output acsr_word_t tx_push_o,
	output logic tx_send_enable_o,
	output logic fifo_clear_o,
	output logic driver_float_o,
	output logic driver_null_o,
	output logic loopback_test_o,
	output logic [1:0] rx_rate_low_o,
	output logic tx_rate_low_o,
	output logic [4:0] ref_div_ratio_o,
	output logic rx_one_event_pulse_o,
	output logic rx_two_event_pulse_o,
	output logic rx_one_level_out_o,
	output logic rx_two_level_out_o
);
	acsr_state_t st_reg;
	acsr_state_t st_next;
	logic [1:0][7:0] rx_stat;
	logic [7:0] tx_stat;
	logic [1:0] level_out;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction

	function automatic logic [2:0] levels(input logic [5:0] c);
		return {c == Q_FULL, c >= Q_HALF, c == 6'h00};
	endfunction

	function automatic logic flag_sel(input logic [1:0] code, input logic [5:0] c);
		logic [2:0] l;
		l = levels(c);
		case (code)
			FLAG_EMPTY: return l[0];
			FLAG_FULL: return l[2];
			FLAG_HALF: return l[1];
			default: return !l[0];
		endcase
	endfunction

	// byte k of a read transfer; out-of-range bytes read as zero
	function automatic logic [7:0] read_byte(input acsr_state_t s, input logic [7:0] o, input logic [5:0] k,
			input logic [31:0] w);
		logic [7:0] b;
		logic [7:0] d;
		b = '0;
		if (o == OP_RD_TXS && k == 6'h00) b = tx_stat;
		if (o == OP_RD_TXC && k == 6'h00) b = s.tx_ctl;
		if (o == OP_RD_PIN && k == 6'h00) b = s.pin;
		if (o == OP_RD_DIV && k == 6'h00) b = s.div;
		for (int n = 0; n < 2; n++) begin
			d = n[0] ? RX2_RD_STEP : 8'h00;
			if (o == 8'(OP_RD_RXS + d) && k == 6'h00) b = rx_stat[n];
			if (o == 8'(OP_RD_RXC + d) && k == 6'h00) b = s.rx_ctl[n];
			if (o == 8'(OP_RD_LAB + d) && k < LEN_LAB) b = s.lab[n][{~k[4:0], 3'b000} +: 8];
			if (o == 8'(OP_RD_PLM + d) && k < LEN_PLM) b = s.match[n][2'd2 - k[1:0]];
			if (o == 8'(OP_RD_FIFO + d) && k < LEN_WORD) b = w[{~k[1:0], 3'b000} +: 8];
			for (int m = 0; m < N_MB; m++) begin
				if (o == 8'(OP_RD_MB + d + 8'(m) * MB_STEP) && k < LEN_PLM) begin
					b = s.mbox[n][m][{2'd2 - k[1:0], 3'b000} +: 8];
				end
			end
		end
		return b;
	endfunction

	always_comb begin
		tx_stat = {5'b00000, levels(tx_count_i)};
		for (int n = 0; n < 2; n++) begin
			rx_stat[n] = {2'b00, st_reg.capt[n], levels(rx_count_i[n])};
			level_out[n] = flag_sel(st_reg.pin[n * PIN_RX_STEP + PIN_FLAG_LSB +: 2], rx_count_i[n]);
		end
	end

	logic [7:0] op_in;
	assign op_in = op_code_i & OP_MASK;

	always_comb begin
		logic [7:0] d;
		logic [7:0] wd;
		logic [7:0] lbl;
		logic [31:0] w;
		logic [31:0] fw;
		logic [5:0] k;
		logic sd_ok;
		logic fifo_ok;
		logic [2:0] hit;
		logic [1:0] code;
		d = '0;
		wd = '0;
		lbl = '0;
		w = '0;
		fw = st_reg.word;
		k = st_reg.cnt;
		sd_ok = 1'b0;
		fifo_ok = 1'b0;
		hit = '0;
		code = '0;
		st_next = st_reg;
		st_next.rx_push = '0;
		st_next.tx_push = '0;
		st_next.ev = '0;
		st_next.clr = 1'b0;
		rx_pop_o = '0;
		// manual send ends once the queue has drained
		if (tx_count_i == 6'h00) st_next.tx_go = 1'b0;
		// bytes of the current transfer
		if (wr_byte_valid_i) begin
			st_next.cnt = (k == 6'h3F) ? k : 6'(k + 6'h01);
			if (st_reg.op == OP_WR_TXC && k == 6'h00) st_next.tx_ctl = wr_byte_i;
			if (st_reg.op == OP_WR_PIN && k == 6'h00) st_next.pin = wr_byte_i;
			if (st_reg.op == OP_WR_DIV && k == 6'h00) st_next.div = wr_byte_i & DIV_MASK;
			if (st_reg.op == OP_WR_TXF && k < LEN_WORD) begin
				st_next.word = {st_reg.word[23:0], wr_byte_i};
				if (k == 6'(LEN_WORD - 6'h01)) st_next.tx_push = {1'b1, st_reg.word[23:0], wr_byte_i};
			end
			for (int n = 0; n < 2; n++) begin
				wd = n[0] ? RX2_WR_STEP : 8'h00;
				if (st_reg.op == 8'(OP_WR_RXC + wd) && k == 6'h00) st_next.rx_ctl[n] = wr_byte_i;
				if (st_reg.op == 8'(OP_WR_LAB + wd) && k < LEN_LAB) begin
					st_next.lab[n][{~k[4:0], 3'b000} +: 8] = wr_byte_i;
				end
				if (st_reg.op == 8'(OP_WR_PLM + wd) && k < LEN_PLM) st_next.match[n][2'd2 - k[1:0]] = wr_byte_i;
			end
		end
		// read bytes are fetched one ahead so the shifter always finds the next one ready
		if (rd_byte_req_i) begin
			st_next.cnt = (k == 6'h3F) ? k : 6'(k + 6'h01);
			st_next.rd_byte = read_byte(st_reg, st_reg.op, 6'(k + 6'h01), st_reg.word);
		end
		if (op_start_i) begin
			st_next.op = op_in;
			st_next.cnt = '0;
			for (int n = 0; n < 2; n++) begin
				d = n[0] ? RX2_RD_STEP : 8'h00;
				if (op_in == 8'(OP_RD_FIFO + d)) begin
					rx_pop_o[n] = rx_count_i[n] != 6'h00;
					fw = rx_head_i[n];
					st_next.word = rx_head_i[n];
				end
				for (int m = 0; m < N_MB; m++) begin
					if (op_in == 8'(OP_RD_MB + d + 8'(m) * MB_STEP)) st_next.capt[n][m] = 1'b0;
				end
				if (op_in == 8'(OP_SET_LAB + (n[0] ? SET_LAB_STEP : 8'h00))) st_next.lab[n] = '1;
			end
			st_next.rd_byte = read_byte(st_reg, op_in, 6'h00, fw);
			if (op_in == OP_TX_GO && !st_reg.tx_ctl[TC_AUTO]) st_next.tx_go = 1'b1;
			if (op_in == OP_SR) begin
				st_next.mbox = '0;
				st_next.capt = '0;
				st_next.clr = 1'b1;
			end
			if (op_in == OP_MR) begin
				st_next = '0;
				st_next.clr = 1'b1;
			end
		end
		// word handed to the serialiser, taken after the flip and parity stages
		if (tx_load_i) begin
			w = tx_head_i;
			if (st_reg.tx_ctl[TC_FLIP]) w[7:0] = rev8(tx_head_i[7:0]);
			if (st_reg.tx_ctl[TC_PINS]) w[31] = st_reg.tx_ctl[TC_SENSE] ^ ~(^tx_head_i[30:0]);
			st_next.tx_word = w;
		end
		// receive words: handled after the host so a capture beats a clear in the same cycle
		for (int n = 0; n < 2; n++) begin
			w = rx_word_i[n].word;
			if (st_reg.rx_ctl[n][RC_FLIP]) w[7:0] = rev8(rx_word_i[n].word[7:0]);
			if (st_reg.rx_ctl[n][RC_PAR]) w[31] = ~(^rx_word_i[n].word);
			lbl = w[7:0];
			sd_ok = !st_reg.rx_ctl[n][RC_SRC_DEST_FILTER_ENABLE] ||
				(w[8] == st_reg.rx_ctl[n][RC_SD9] && w[9] == st_reg.rx_ctl[n][RC_SRC_DEST_COMPARE_HI]);
			fifo_ok = rx_word_i[n].valid && sd_ok && (!st_reg.rx_ctl[n][RC_LABF] || st_reg.lab[n][lbl]);
			for (int m = 0; m < N_MB; m++) begin
				// match values are compared as written, never flipped
				hit[m] = rx_word_i[n].valid && sd_ok && st_reg.rx_ctl[n][RC_PRIORITY_CAPTURE_ENABLE] &&
					lbl == st_reg.match[n][m];
				if (hit[m]) begin
					st_next.mbox[n][m] = w[31:8];
					st_next.capt[n][m] = 1'b1;
				end
			end
			st_next.rx_push[n] = {fifo_ok, w};
			code = st_reg.pin[n * PIN_RX_STEP + PIN_INT_LSB +: 2];
			st_next.ev[n] = (code == INT_ANY) ? (fifo_ok || |hit) : hit[code - 2'd1];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_byte_o = st_reg.rd_byte;
	assign rx_push_o = st_reg.rx_push;
	assign tx_push_o = st_reg.tx_push;
	assign tx_word_o = st_reg.tx_word;
	assign tx_send_enable_o = st_reg.tx_ctl[TC_AUTO] || st_reg.tx_go;
	assign fifo_clear_o = st_reg.clr;
	assign driver_float_o = st_reg.tx_ctl[TC_FLOAT];
	// loopback keeps test words off the bus and makes the receivers listen to the transmitter only
	assign driver_null_o = st_reg.tx_ctl[TC_LOOP];
	assign loopback_test_o = st_reg.tx_ctl[TC_LOOP];
	assign rx_rate_low_o = {st_reg.rx_ctl[1][CTL_RATE], st_reg.rx_ctl[0][CTL_RATE]};
	assign tx_rate_low_o = st_reg.tx_ctl[CTL_RATE];
	assign ref_div_ratio_o = (st_reg.div == 8'h00) ? DIV_UNITY : st_reg.div[4:0];
	assign rx_one_event_pulse_o = st_reg.ev[0];
	assign rx_two_event_pulse_o = st_reg.ev[1];
	assign rx_one_level_out_o = level_out[0];
	assign rx_two_level_out_o = level_out[1];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_rx_flip_label: assert property (rx_word_i[0].valid && st_reg.rx_ctl[0][RC_FLIP] && !op_start_i
		|=> rx_push_o[0].word[7:0] == rev8($past(rx_word_i[0].word[7:0]))) else $error("label not reversed");
	a_sd_filter_drop: assert property (rx_word_i[0].valid && st_reg.rx_ctl[0][RC_SRC_DEST_FILTER_ENABLE] &&
		rx_word_i[0].word[8] != st_reg.rx_ctl[0][RC_SD9] |=> !rx_push_o[0].valid) else $error("sd mismatch stored");
	a_rx_parity_check: assert property (rx_word_i[1].valid && st_reg.rx_ctl[1][RC_PAR]
		|=> rx_push_o[1].word[31] == !(^$past(rx_word_i[1].word))) else $error("parity bit wrong");
	a_rx_parity_off: assert property (rx_word_i[0].valid && st_reg.rx_ctl[0][7:2] == 6'h00
		|=> rx_push_o[0].valid && rx_push_o[0].word == $past(rx_word_i[0].word)) else $error("word altered");
	a_label_filter_on: assert property (rx_word_i[0].valid && st_reg.rx_ctl[0][RC_LABF] &&
		!st_reg.lab[0][rx_word_i[0].word[7:0]] && !st_reg.rx_ctl[0][RC_FLIP] |=> !rx_push_o[0].valid)
		else $error("filtered label stored");
	a_no_capture: assert property (!st_reg.rx_ctl[0][RC_PRIORITY_CAPTURE_ENABLE] && !op_start_i
		|=> st_reg.mbox[0] == $past(st_reg.mbox[0])) else $error("mailbox written while off");
	a_float_write: assert property (st_reg.op == OP_WR_TXC && wr_byte_valid_i && st_reg.cnt == 6'h00 &&
		!op_start_i ##1 1'b1 |-> driver_float_o == $past(wr_byte_i[7])) else $error("float not applied");
	a_tx_parity_odd: assert property (tx_load_i && st_reg.tx_ctl[TC_PINS] && !st_reg.tx_ctl[TC_SENSE]
		|=> ^tx_word_o) else $error("odd parity wrong");
	// a control write that turns auto mode on is the one legal way to raise the enable without the command
	a_tx_hold_manual: assert property (!st_reg.tx_ctl[TC_AUTO] && !st_reg.tx_go && !op_start_i
		&& !(wr_byte_valid_i && st_reg.op == OP_WR_TXC)
		|=> !tx_send_enable_o) else $error("sent without command");
	a_status_zero_bits: assert property (op_start_i && op_in == OP_RD_TXS
		|=> rd_byte_o[7:3] == 5'b00000 && rd_byte_o[0] == $past(tx_count_i == 6'h00)) else $error("tx status");
	a_mbox_read_clear: assert property (op_start_i && op_in == OP_RD_MB && !rx_word_i[0].valid
		|=> !st_reg.capt[0][0]) else $error("capture bit kept");
	// a capture in the same cycle legally wins over the clear
	a_soft_reset_keep: assert property (op_start_i && op_in == OP_SR && !rx_word_i[0].valid && !rx_word_i[1].valid
		|=> fifo_clear_o && st_reg.tx_ctl == $past(st_reg.tx_ctl) && st_reg.capt == '0) else $error("soft reset");
	a_event_any: assert property (rx_word_i[0].valid && st_reg.pin[3:2] == INT_ANY &&
		st_reg.rx_ctl[0][RC_SRC_DEST_FILTER_ENABLE +: 1] == 1'b0 && !st_reg.rx_ctl[0][RC_LABF] |=> rx_one_event_pulse_o)
		else $error("no event pulse");
	a_event_mailbox: assert property (rx_word_i[0].valid && st_reg.pin[3:2] == 2'h1 &&
		st_reg.rx_ctl[0][RC_PRIORITY_CAPTURE_ENABLE] && !st_reg.rx_ctl[0][RC_SRC_DEST_FILTER_ENABLE] && !st_reg.rx_ctl[0][RC_FLIP] &&
		rx_word_i[0].word[7:0] == st_reg.match[0][0] |=> rx_one_event_pulse_o) else $error("no mailbox pulse");
	a_tx_parity_even: assert property (tx_load_i && st_reg.tx_ctl[TC_PINS] && st_reg.tx_ctl[TC_SENSE]
		|=> !(^tx_word_o)) else $error("even parity wrong");
	a_tx_flip_label: assert property (tx_load_i && st_reg.tx_ctl[TC_FLIP]
		|=> tx_word_o[7:0] == rev8($past(tx_head_i[7:0]))) else $error("tx label not reversed");
	a_rx_status_bits: assert property (op_start_i && op_in == OP_RD_RXS
		|=> rd_byte_o[7:6] == 2'b00 && rd_byte_o[0] == $past(rx_count_i[0] == 6'h00)) else $error("rx status");
endmodule
`default_nettype wire

// [acsr_queue_model.sv]
/*
 * Behavioural queues behind the register bank: both receive queues and the transmit queue.
 * Assumes pushes, pops, loads and the clear request are one-cycle pulses on clk_i.
 */
`default_nettype none
module acsr_queue_model
	import acsr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire acsr_word_t [1:0] rx_push_i,
	input wire logic [1:0] rx_pop_i,
	input wire acsr_word_t tx_push_i,
	input wire logic tx_load_i,
	output logic [1:0][5:0] rx_count_o,
	output logic [1:0][31:0] rx_head_o,
	output logic [5:0] tx_count_o,
	output logic [31:0] tx_head_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] q[3][$];
	logic [2:0][5:0] cnt;
	logic [2:0][31:0] head;
	logic [31:0] junk;
	wire logic [2:0] push_v = {tx_push_i.valid, rx_push_i[1].valid, rx_push_i[0].valid};
	wire logic [2:0][31:0] push_w = {tx_push_i.word, rx_push_i[1].word, rx_push_i[0].word};
	wire logic [2:0] take = {tx_load_i, rx_pop_i};
	always @(posedge clk_i or posedge rst_i) begin
		// an empty head toggles each cycle so a stale value can never pass for data
		junk = rst_i ? 32'h5A5A_A5A5 : ~junk;
		for (int n = 0; n < 3; n++) begin
			if (rst_i || clear_i) begin
				q[n].delete();
			end else begin
				if (take[n] && q[n].size() > 0) begin
					void'(q[n].pop_front());
				end
				if (push_v[n] && q[n].size() < 32) begin
					q[n].push_back(push_w[n]);
				end
			end
			// non-blocking so the register bank samples the counts of the cycle before the edge
			cnt[n] <= 6'(q[n].size());
			head[n] <= (q[n].size() > 0) ? q[n][0] : junk;
		end
	end
	assign rx_count_o = cnt[1:0];
	assign rx_head_o = head[1:0];
	assign tx_count_o = cnt[2];
	assign tx_head_o = head[2];
endmodule
`default_nettype wire

// [test_acsr_regs.sv]
/*
 * Self-checking bench for the register bank, with the queue model on its far side.
 * Assumes the bench plays the serial shifter, the receive word validators and the serialiser.
 */
`default_nettype none
module test_acsr_regs
	import acsr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] ctl;
		logic [31:0] w;
		logic keep;
		logic [31:0] exp;
	} acsr_row_t;
	acsr_row_t rows [11] = '{
		'{8'h00, 32'h1234_5678, 1'b1, 32'h1234_5678},
		'{8'h80, 32'h1, 1'b1, 32'h80},
		'{8'h08, 32'h1, 1'b1, 32'h1},
		'{8'h08, 32'h3, 1'b1, 32'h8000_0003},
		'{8'h88, 32'h8000_0003, 1'b1, 32'h0000_00C0},
		'{8'h10, 32'h100, 1'b0, 32'h0},
		'{8'h70, 32'h300, 1'b1, 32'h300},
		'{8'h50, 32'h200, 1'b0, 32'h0},
		'{8'h04, 32'h5, 1'b0, 32'h0},
		'{8'h30, 32'h5, 1'b0, 32'h0},
		'{8'h01, 32'h7, 1'b1, 32'h7}};
	logic [7:0] zero_ops [6] = '{8'h84, 8'h94, 8'hB4, 8'hD0, 8'hD4, 8'hFF};
	logic clk_i = 1'b0, rst_i = 1'b1, op_start_i = 1'b0, wr_byte_valid_i = 1'b0, rd_byte_req_i = 1'b0, tx_load_i = 1'b0;
	logic [7:0] op_code_i = 8'h0, wr_byte_i = 8'h0, rd_byte_o;
	acsr_word_t [1:0] rx_word_i = '0;
	acsr_word_t [1:0] rx_push_o;
	acsr_word_t tx_push_o;
	logic [1:0][5:0] rx_count_i;
	logic [1:0][31:0] rx_head_i;
	logic [1:0] rx_pop_o, rx_rate_low_o;
	logic [5:0] tx_count_i;
	logic [31:0] tx_head_i, tx_word_o;
	logic [4:0] ref_div_ratio_o;
	logic tx_send_enable_o, fifo_clear_o, driver_float_o, driver_null_o, loopback_test_o, tx_rate_low_o;
	logic rx_one_event_pulse_o, rx_two_event_pulse_o, rx_one_level_out_o, rx_two_level_out_o;
	int err_total = 0, checks_done = 0, cycles = 0;
	acsr_regs uut (.clk_i, .rst_i, .op_start_i, .op_code_i, .wr_byte_valid_i, .wr_byte_i, .rd_byte_req_i,
		.rd_byte_o, .rx_word_i, .rx_count_i, .rx_head_i, .rx_pop_o, .rx_push_o, .tx_count_i, .tx_load_i,
		.tx_head_i, .tx_word_o, .tx_push_o, .tx_send_enable_o, .fifo_clear_o, .driver_float_o, .driver_null_o,
		.loopback_test_o, .rx_rate_low_o, .tx_rate_low_o, .ref_div_ratio_o, .rx_one_event_pulse_o,
		.rx_two_event_pulse_o, .rx_one_level_out_o, .rx_two_level_out_o);
	acsr_queue_model far (.clk_i, .rst_i, .clear_i(fifo_clear_o), .rx_push_i(rx_push_o), .rx_pop_i(rx_pop_o),
		.tx_push_i(tx_push_o), .tx_load_i, .rx_count_o(rx_count_i), .rx_head_o(rx_head_i),
		.tx_count_o(tx_count_i), .tx_head_o(tx_head_i));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// write bytes go most significant first, longer transfers repeat the word; returns in the cycle the effect shows
	task automatic send(input logic [7:0] op, input int nb, input logic [31:0] d);
		@(posedge clk_i);
		op_start_i <= 1'b1;
		op_code_i <= op;
		@(posedge clk_i);
		op_start_i <= 1'b0;
		for (int k = nb - 1; k >= 0; k--) begin
			wr_byte_valid_i <= 1'b1;
			wr_byte_i <= d[8*(k % 4) +: 8];
			@(posedge clk_i);
		end
		wr_byte_valid_i <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic get(input logic [7:0] op, input int nb, output logic [31:0] v);
		v = '0;
		@(posedge clk_i);
		op_start_i <= 1'b1;
		op_code_i <= op;
		@(posedge clk_i);
		op_start_i <= 1'b0;
		for (int k = 0; k < nb; k++) begin
			if (k > 0) begin
				@(posedge clk_i);
				rd_byte_req_i <= 1'b1;
				@(posedge clk_i);
				rd_byte_req_i <= 1'b0;
			end
			@(negedge clk_i);
			v = {v[23:0], rd_byte_o};
		end
	endtask
	task automatic rxw(input int n, input logic [31:0] w);
		@(posedge clk_i);
		rx_word_i[n] <= '{valid: 1'b1, word: w};
		@(posedge clk_i);
		rx_word_i[n].valid <= 1'b0;
		@(negedge clk_i);
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			finish_test();
		end
	end
	initial begin
		logic [31:0] v;
		logic [31:0] e;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		get(OP_RD_TXS, 1, v);
		chk(v, 32'h1);
		get(OP_RD_RXS, 1, v);
		chk(v, 32'h1);
		foreach (zero_ops[i]) begin
			get(zero_ops[i], 1, v);
			chk(v, 32'h0);
		end
		chk(ref_div_ratio_o, 5'h1);
		chk(rx_one_level_out_o, 1'b1);
		chk(rx_two_level_out_o, 1'b1);
		chk(tx_send_enable_o, 1'b0);
		foreach (rows[i]) begin
			send(OP_WR_RXC, 1, {24'h0, rows[i].ctl});
			rxw(0, rows[i].w);
			chk(rx_push_o[0].valid, rows[i].keep);
			chk(rx_one_event_pulse_o, rows[i].keep);
			if (rows[i].keep) chk(rx_push_o[0].word, rows[i].exp);
		end
		chk(rx_rate_low_o, 2'b01);
		send(OP_WR_RXC + RX2_WR_STEP, 1, 32'h88);
		rxw(1, 32'h1);
		chk(rx_push_o[1].word, 32'h80);
		chk(rx_two_event_pulse_o, 1'b1);
		send(OP_SR, 0, 32'h0);
		chk(fifo_clear_o, 1'b1);
		get(OP_RD_RXC, 1, v);
		chk(v, 32'h1);
		get(OP_RD_RXS, 1, v);
		chk(v, 32'h1);
		send(OP_WR_RXC, 1, 32'h2);
		send(OP_WR_PLM, 3, 32'h0033_2211);
		send(OP_WR_PIN, 1, 32'h4);
		rxw(0, 32'hCAFE_0011);
		chk(rx_one_event_pulse_o, 1'b1);
		get(OP_RD_RXS, 1, v);
		chk(v, 32'h08);
		rxw(0, 32'h0BAD_0022);
		chk(rx_one_event_pulse_o, 1'b0);
		get(OP_RD_RXS, 1, v);
		chk(v, 32'h18);
		get(OP_RD_MB, 3, v);
		chk(v, 32'h00CA_FE00);
		get(OP_RD_RXS, 1, v);
		chk(v, 32'h10);
		get(OP_RD_PLM, 3, v);
		chk(v, 32'h0033_2211);
		for (int c = 0; c < 4; c++) begin
			send(OP_WR_PIN, 1, 32'(4 + c));
			chk(rx_one_level_out_o, c == 3);
		end
		get(OP_RD_FIFO, 4, v);
		chk(v, 32'hCAFE_0011);
		send(OP_WR_RXC, 1, 32'h4);
		send(OP_SET_LAB, 0, 32'h0);
		rxw(0, 32'h5);
		chk(rx_push_o[0].valid, 1'b1);
		send(OP_WR_DIV, 1, 32'hFF);
		get(OP_RD_DIV, 1, v);
		chk(v, 32'h1E);
		chk(ref_div_ratio_o, 5'h1E);
		send(OP_WR_TXC, 1, 32'h44);
		send(OP_WR_TXF, 4, 32'hA1B2_C3D4);
		chk(tx_push_o.word, 32'hA1B2_C3D4);
		chk(tx_push_o.valid, 1'b1);
		get(OP_RD_TXS, 1, v);
		chk(v, 32'h0);
		chk(tx_send_enable_o, 1'b0);
		send(OP_TX_GO, 0, 32'h0);
		chk(tx_send_enable_o, 1'b1);
		@(posedge clk_i);
		tx_load_i <= 1'b1;
		@(posedge clk_i);
		tx_load_i <= 1'b0;
		@(negedge clk_i);
		e = 32'hA1B2_C3D4;
		e[7:0] = {<<{e[7:0]}};
		e[31] = ~^e[30:0];
		chk(tx_word_o, e);
		send(OP_WR_TXC, 1, 32'hB1);
		chk({driver_float_o, driver_null_o, loopback_test_o, tx_send_enable_o, tx_rate_low_o}, 5'h1F);
		send(OP_MR, 0, 32'h0);
		get(OP_RD_TXC, 1, v);
		chk(v, 32'h0);
		send(OP_WR_LAB + RX2_WR_STEP, 32, 32'h8000_0000);
		get(OP_RD_LAB + RX2_RD_STEP, 4, v);
		chk(v, 32'h8000_0000);
		send(OP_WR_RXC + RX2_WR_STEP, 1, 32'h4);
		rxw(1, 32'h1F);
		chk(rx_push_o[1].valid, 1'b1);
		rxw(1, 32'h1E);
		chk(rx_push_o[1].valid, 1'b0);
		chk(rx_two_event_pulse_o, 1'b0);
		get(OP_RD_FIFO + RX2_RD_STEP, 4, v);
		chk(v, 32'h1F);
		get(OP_RD_RXS + RX2_RD_STEP, 1, v);
		chk(v, 32'h1);
		send(OP_WR_TXC, 1, 32'hC);
		send(OP_WR_TXF, 4, 32'h1);
		@(posedge clk_i);
		tx_load_i <= 1'b1;
		@(posedge clk_i);
		tx_load_i <= 1'b0;
		@(negedge clk_i);
		chk(tx_word_o, 32'h8000_0001);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		get(OP_RD_TXC, 1, v);
		chk(v, 32'h0);
		get(OP_RD_LAB + RX2_RD_STEP, 1, v);
		chk(v, 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
